// ### hdl/fsp_pkg.sv
// constants, opcodes and sector grouping for flash sector protection
package fsp_pkg;

    // ******************************
    // geometry
    // ******************************
    localparam int NUM_SEC  = 46;
    localparam int NUM_BOOT = 8;
    localparam int NUM_PPB  = 24;
    localparam int SEC_W    = 6;
    localparam int PPB_W    = 5;

    // ******************************
    // commands
    // ******************************
    localparam logic [2:0] OP_PROG      = 3'h0;
    localparam logic [2:0] OP_ERASE     = 3'h1;
    localparam logic [2:0] OP_PPB_PROG  = 3'h2;
    localparam logic [2:0] OP_PPB_ERASE = 3'h3;
    localparam logic [2:0] OP_LOCK_SET  = 3'h4;
    localparam logic [2:0] OP_DYB_WRITE = 3'h5;
    localparam logic [2:0] OP_VERIFY    = 3'h6;

    // ******************************
    // reset values and protected pair
    // ******************************
    localparam logic             LOCK_RST   = 1'b0;
    localparam logic             DYB_RST    = 1'b0;
    localparam logic             PPB_RST    = 1'b0;
    localparam logic [SEC_W-1:0] WP_SEC_LO  = 6'h00;
    localparam logic [SEC_W-1:0] WP_SEC_HI  = 6'h01;

    // ******************************
    // timing
    // ******************************
    localparam int         CLK_NS         = 100;
    localparam int         PROG_POLL_NS   = 1000;
    localparam int         ERASE_POLL_NS  = 50000;
    localparam int         PROG_POLL_CYC  = (PROG_POLL_NS + CLK_NS - 1) / CLK_NS;
    localparam int         ERASE_POLL_CYC = (ERASE_POLL_NS + CLK_NS - 1) / CLK_NS;
    localparam int         TMR_W          = 10;
    localparam int         PPB_OP_CYC     = 4;
    localparam int         PPB_ERASE_LIM  = 100;
    localparam int         ERASE_CNT_W    = 8;

    // state of the command sequencer
    typedef enum logic [2:0] {
        ST_READ = 3'b001,
        ST_POLL = 3'b010,
        ST_PPB  = 3'b100
    } fsp_state_t;

    // sector to persistent bit: boot sectors own bits, middle sectors 3,4,..,4,3
    function automatic logic [PPB_W-1:0] fsp_ppb_index(input logic [SEC_W-1:0] sec);
        int s;
        int m;
        int idx;
        s = int'(sec);
        m = s - NUM_BOOT;
        if (s < NUM_BOOT) begin
            idx = s;
        end else if (s >= NUM_SEC - NUM_BOOT) begin
            idx = s - (NUM_SEC - NUM_BOOT) + 16;
        end else if (m < 3) begin
            idx = 8;
        end else if (m >= 27) begin
            idx = 15;
        end else begin
            idx = 9 + (m - 3) / 4;
        end
        return idx[PPB_W-1:0];
    endfunction

endpackage

// ### hdl/fsp_poll_timer.sv
// down counter that holds status polling for a loaded number of cycles
`timescale 1ns/1ns
module fsp_poll_timer
    import fsp_pkg::*;
#(
    parameter int W = TMR_W
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // control
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    // status
    output logic              busy
);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (start) begin
            cnt_nxt = load;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign busy = (cnt_r != '0);

    load_count_a: assert property (@(posedge clk) disable iff (!rst_b)
        start && load != '0 |=> busy) else $error("timer did not start");

endmodule // fsp_poll_timer

// ### hdl/fsp_ppb_store.sv
// persistent protection bit array, kept across hardware reset
`timescale 1ns/1ns
module fsp_ppb_store
    import fsp_pkg::*;
#(
    parameter int N      = NUM_PPB,
    parameter int OP_CYC = PPB_OP_CYC
) (
    // clock and as-delivered init
    input  wire logic                   clk,
    input  wire logic                   nv_init_b,
    // operations
    input  wire logic                   prog_go,
    input  wire logic                   erase_go,
    input  wire logic [PPB_W-1:0]       prog_idx,
    // state
    output logic [N-1:0]                ppb,
    output logic                        busy,
    output logic [ERASE_CNT_W-1:0]      erase_cnt
);

    logic [N-1:0]             ppb_r;
    logic [N-1:0]             ppb_nxt;
    logic [3:0]               op_r;
    logic [3:0]               op_nxt;
    logic [ERASE_CNT_W-1:0]   ecnt_r;
    logic [ERASE_CNT_W-1:0]   ecnt_nxt;

    always_comb begin
        ppb_nxt  = ppb_r;
        op_nxt   = (op_r != 4'h0) ? op_r - 4'h1 : 4'h0;
        ecnt_nxt = ecnt_r;
        if (erase_go) begin
            ppb_nxt = '0;
            op_nxt  = 4'(OP_CYC);
            if (ecnt_r != '1) begin
                ecnt_nxt = ecnt_r + 1'b1;
            end
        end else if (prog_go) begin
            ppb_nxt[prog_idx] = 1'b1;
            op_nxt            = 4'(OP_CYC);
        end
    end

    // only the as-delivered init clears, hardware reset does not
    always_ff @(posedge clk) begin
        if (!nv_init_b) begin
            ppb_r  <= {N{PPB_RST}};
            op_r   <= 4'h0;
            ecnt_r <= '0;
        end else begin
            ppb_r  <= ppb_nxt;
            op_r   <= op_nxt;
            ecnt_r <= ecnt_nxt;
        end
    end

    assign ppb       = ppb_r;
    assign busy      = (op_r != 4'h0);
    assign erase_cnt = ecnt_r;

    erase_all_a: assert property (@(posedge clk) disable iff (!nv_init_b)
        erase_go |=> ppb_r == '0) else $error("persistent erase left bits set");

    prog_one_a: assert property (@(posedge clk) disable iff (!nv_init_b)
        prog_go && !erase_go |=> ppb_r[$past(prog_idx)]
            && ((ppb_r ^ $past(ppb_r)) & ~(N'(1) << $past(prog_idx))) == '0)
        else $error("persistent program touched other bits");

endmodule // fsp_ppb_store

// ### hdl/fsp_sector_protect.sv
// command sequencer deciding whether program or erase reaches a sector
`timescale 1ns/1ns
module fsp_sector_protect
    import fsp_pkg::*;
(
    // clock and resets
    input  wire logic               CORE_CLK,
    input  wire logic               RST_B,
    input  wire logic               NV_INIT_B,
    // hardware write protect
    input  wire logic               WP_B,
    // command from host
    input  wire logic               CMD_VALID,
    input  wire logic [2:0]         CMD_OP,
    input  wire logic [SEC_W-1:0]   CMD_SECTOR,
    input  wire logic               CMD_DATA,
    // sequencer status
    output logic                    CMD_READY,
    output logic                    POLL_BUSY,
    output logic                    CMD_REJECT,
    // array operations let through
    output logic                    ARRAY_PROG_GO,
    output logic                    ARRAY_ERASE_GO,
    output logic [SEC_W-1:0]        ARRAY_SECTOR,
    // verify answer
    output logic                    VERIFY_VALID,
    output logic                    VERIFY_DYB,
    output logic                    VERIFY_PPB,
    output logic                    VERIFY_LOCK,
    // global state
    output logic                    LOCK_STATE,
    output logic                    PPB_WORN
);

    // ******************************
    // storage and wires
    // ******************************
    fsp_state_t             state_r;
    fsp_state_t             state_nxt;
    logic                   lock_r;
    logic                   lock_nxt;
    logic [NUM_SEC-1:0]     dyb_r;
    logic [NUM_SEC-1:0]     dyb_nxt;
    logic [NUM_PPB-1:0]     ppb_vec;
    logic                   ppb_busy;
    logic [ERASE_CNT_W-1:0] erase_cnt;
    logic                   tmr_busy;
    logic                   tmr_start;
    logic [TMR_W-1:0]       tmr_load;
    logic                   ppb_prog_go;
    logic                   ppb_erase_go;
    logic                   accept;
    logic                   sec_prot;
    logic                   wp_hit;
    logic [PPB_W-1:0]       sec_ppb_idx;

    logic                   ready_r;
    logic                   busy_r;
    logic                   reject_r;
    logic                   pgo_r;
    logic                   ego_r;
    logic [SEC_W-1:0]       asec_r;
    logic                   vval_r;
    logic                   vdyb_r;
    logic                   vppb_r;
    logic                   vlock_r;
    logic                   worn_r;
    logic                   ready_nxt;
    logic                   busy_nxt;
    logic                   reject_nxt;
    logic                   pgo_nxt;
    logic                   ego_nxt;
    logic [SEC_W-1:0]       asec_nxt;
    logic                   vval_nxt;
    logic                   vdyb_nxt;
    logic                   vppb_nxt;
    logic                   vlock_nxt;
    logic                   worn_nxt;

    // ******************************
    // protection decision
    // ******************************
    assign accept      = CMD_VALID && (state_r == ST_READ);
    assign sec_ppb_idx = fsp_ppb_index(CMD_SECTOR);
    assign wp_hit      = !WP_B && (CMD_SECTOR == WP_SEC_LO || CMD_SECTOR == WP_SEC_HI);
    assign sec_prot    = ppb_vec[sec_ppb_idx] | dyb_r[CMD_SECTOR] | wp_hit;

    // ******************************
    // sequencer and protection bits
    // ******************************
    always_comb begin
        state_nxt    = state_r;
        lock_nxt     = lock_r;
        dyb_nxt      = dyb_r;
        tmr_start    = 1'b0;
        tmr_load     = '0;
        ppb_prog_go  = 1'b0;
        ppb_erase_go = 1'b0;
        reject_nxt   = 1'b0;
        pgo_nxt      = 1'b0;
        ego_nxt      = 1'b0;
        asec_nxt     = asec_r;
        vval_nxt     = 1'b0;
        vdyb_nxt     = vdyb_r;
        vppb_nxt     = vppb_r;
        vlock_nxt    = vlock_r;
        case (state_r)
            ST_READ: begin
                if (accept) begin
                    case (CMD_OP)
                        OP_PROG, OP_ERASE: begin
                            if (sec_prot) begin
                                // protected: poll, then back to read
                                reject_nxt = 1'b1;
                                tmr_start  = 1'b1;
                                // read mode returns one cycle after the timer empties
                                tmr_load   = (CMD_OP == OP_PROG) ?
                                    TMR_W'(PROG_POLL_CYC - 1) :
                                    TMR_W'(ERASE_POLL_CYC - 1);
                                state_nxt  = ST_POLL;
                            end else begin
                                pgo_nxt  = (CMD_OP == OP_PROG);
                                ego_nxt  = (CMD_OP == OP_ERASE);
                                asec_nxt = CMD_SECTOR;
                            end
                        end
                        OP_PPB_PROG, OP_PPB_ERASE: begin
                            if (lock_r) begin
                                reject_nxt = 1'b1;
                            end else begin
                                ppb_prog_go  = (CMD_OP == OP_PPB_PROG);
                                ppb_erase_go = (CMD_OP == OP_PPB_ERASE);
                                state_nxt    = ST_PPB;
                            end
                        end
                        OP_LOCK_SET: begin
                            lock_nxt = 1'b1;
                        end
                        OP_DYB_WRITE: begin
                            dyb_nxt[CMD_SECTOR] = CMD_DATA;
                        end
                        OP_VERIFY: begin
                            vval_nxt  = 1'b1;
                            vdyb_nxt  = dyb_r[CMD_SECTOR];
                            vppb_nxt  = ppb_vec[sec_ppb_idx];
                            vlock_nxt = lock_r;
                        end
                        default: begin
                            reject_nxt = 1'b1;
                        end
                    endcase
                end
            end
            ST_POLL: begin
                if (!tmr_busy) begin
                    state_nxt = ST_READ;
                end
            end
            ST_PPB: begin
                if (!ppb_busy) begin
                    state_nxt = ST_READ;
                end
            end
            default: begin
                state_nxt = ST_READ;
            end
        endcase
        ready_nxt = (state_nxt == ST_READ);
        busy_nxt  = (state_nxt != ST_READ);
        worn_nxt  = (erase_cnt >= ERASE_CNT_W'(PPB_ERASE_LIM));
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            state_r  <= ST_READ;
            lock_r   <= LOCK_RST;
            dyb_r    <= {NUM_SEC{DYB_RST}};
            ready_r  <= 1'b1;
            busy_r   <= 1'b0;
            reject_r <= 1'b0;
            pgo_r    <= 1'b0;
            ego_r    <= 1'b0;
            asec_r   <= '0;
            vval_r   <= 1'b0;
            vdyb_r   <= 1'b0;
            vppb_r   <= 1'b0;
            vlock_r  <= 1'b0;
            worn_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            lock_r   <= lock_nxt;
            dyb_r    <= dyb_nxt;
            ready_r  <= ready_nxt;
            busy_r   <= busy_nxt;
            reject_r <= reject_nxt;
            pgo_r    <= pgo_nxt;
            ego_r    <= ego_nxt;
            asec_r   <= asec_nxt;
            vval_r   <= vval_nxt;
            vdyb_r   <= vdyb_nxt;
            vppb_r   <= vppb_nxt;
            vlock_r  <= vlock_nxt;
            worn_r   <= worn_nxt;
        end
    end

    // ******************************
    // leaves
    // ******************************
    fsp_poll_timer #(
        .W (TMR_W)
    ) u_timer (
        .clk   (CORE_CLK),
        .rst_b (RST_B),
        .start (tmr_start),
        .load  (tmr_load),
        .busy  (tmr_busy)
    );

    fsp_ppb_store #(
        .N      (NUM_PPB),
        .OP_CYC (PPB_OP_CYC)
    ) u_ppb (
        .clk       (CORE_CLK),
        .nv_init_b (NV_INIT_B),
        .prog_go   (ppb_prog_go),
        .erase_go  (ppb_erase_go),
        .prog_idx  (sec_ppb_idx),
        .ppb       (ppb_vec),
        .busy      (ppb_busy),
        .erase_cnt (erase_cnt)
    );

    // ******************************
    // outputs
    // ******************************
    assign CMD_READY      = ready_r;
    assign POLL_BUSY      = busy_r;
    assign CMD_REJECT     = reject_r;
    assign ARRAY_PROG_GO  = pgo_r;
    assign ARRAY_ERASE_GO = ego_r;
    assign ARRAY_SECTOR   = asec_r;
    assign VERIFY_VALID   = vval_r;
    assign VERIFY_DYB     = vdyb_r;
    assign VERIFY_PPB     = vppb_r;
    assign VERIFY_LOCK    = vlock_r;
    assign LOCK_STATE     = lock_r;
    assign PPB_WORN       = worn_r;

    // ******************************
    // checks
    // ******************************
    logic [TMR_W-1:0] poll_len_r;
    logic             poll_erase_r;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
            poll_len_r   <= '0;
            poll_erase_r <= 1'b0;
        end else begin
            poll_len_r   <= busy_r && state_r == ST_POLL ? poll_len_r + 1'b1 : '0;
            poll_erase_r <= tmr_start ? (CMD_OP == OP_ERASE) : poll_erase_r;
        end
    end

    lock_sticky_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        lock_r |=> lock_r) else $error("lock cleared without reset");

    reset_clear_a: assert property (@(posedge CORE_CLK)
        !RST_B |=> !lock_r && dyb_r == '0) else $error("reset left protection set");

    prog_poll_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        state_r == ST_POLL && !tmr_busy && !poll_erase_r
            |-> poll_len_r == TMR_W'(PROG_POLL_CYC - 1) ##1 CMD_READY)
        else $error("program poll length wrong");

    erase_poll_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        state_r == ST_POLL && !tmr_busy && poll_erase_r
            |-> poll_len_r == TMR_W'(ERASE_POLL_CYC - 1) ##1 CMD_READY)
        else $error("erase poll length wrong");

    prot_block_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        accept && (CMD_OP == OP_PROG || CMD_OP == OP_ERASE) |=>
            (ARRAY_PROG_GO || ARRAY_ERASE_GO) == !$past(sec_prot))
        else $error("protection decision wrong");

    wp_block_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        accept && (CMD_OP == OP_PROG || CMD_OP == OP_ERASE) && !WP_B
            && (CMD_SECTOR == WP_SEC_LO || CMD_SECTOR == WP_SEC_HI)
            |=> !ARRAY_ERASE_GO && !ARRAY_PROG_GO)
        else $error("write protect pin ignored");

    lock_refuse_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B || !NV_INIT_B)
        accept && lock_r && (CMD_OP == OP_PPB_PROG || CMD_OP == OP_PPB_ERASE)
            |=> CMD_REJECT && CMD_READY && $stable(ppb_vec))
        else $error("locked persistent bits changed");

    dyb_write_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        accept && CMD_OP == OP_DYB_WRITE |=> dyb_r[$past(CMD_SECTOR)] == $past(CMD_DATA))
        else $error("dynamic bit not written");

    verify_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        accept && CMD_OP == OP_VERIFY |=> VERIFY_VALID && VERIFY_LOCK == lock_r
            && VERIFY_DYB == $past(dyb_r[CMD_SECTOR]))
        else $error("verify answer wrong");

endmodule // fsp_sector_protect

// ### testbench/fsp_host_model.sv
// host-side model issuing commands to the sector protection block
`timescale 1ns/1ns
module fsp_host_model
    import fsp_pkg::*;
(
    // clock and handshake
    input  wire logic             clk,
    input  wire logic             cmd_ready,
    // command out
    output logic                  cmd_valid,
    output logic [2:0]            cmd_op,
    output logic [SEC_W-1:0]      cmd_sector,
    output logic                  cmd_data,
    // write-protect pin
    output logic                  wp_b
);
    initial begin
        cmd_valid  = 1'b0;
        cmd_op     = 3'h7;
        cmd_sector = 6'h3f;
        cmd_data   = 1'b0;
        wp_b       = 1'b1;
    end

    // ******************************
    // one command, raised once ready is seen and held for one edge
    // ******************************
    task automatic send(input logic [2:0] op, input logic [SEC_W-1:0] sec, input logic d);
        int n;
        n = 0;
        // one idle edge so a strobe is never lowered and raised in one step
        @(posedge clk);
        #1;
        while (cmd_ready !== 1'b1 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmd_valid  = 1'b1;
        cmd_op     = op;
        cmd_sector = sec;
        cmd_data   = d;
        @(posedge clk);
        #1;
        cmd_valid  = 1'b0;
        cmd_op     = ~op;
        cmd_sector = ~sec;
        cmd_data   = ~d;
    endtask

    // preprogram every persistent bit, then erase them together
    task automatic erase_all();
        for (int s = 0; s < NUM_SEC; s++) begin
            send(OP_PPB_PROG, 6'(s), 1'b0);
        end
        send(OP_PPB_ERASE, 6'h00, 1'b0);
    endtask

    // boot code: freeze persistent bits, hold write protect low
    task automatic secure_boot();
        wp_b = 1'b0;
        send(OP_LOCK_SET, 6'h00, 1'b0);
    endtask

    // lift the write-protect pin again
    task automatic release_wp();
        wp_b = 1'b1;
    endtask
endmodule // fsp_host_model

// ### testbench/tb_top.sv
// self-checking bench for the sector protection sequencer
`timescale 1ns/1ns
module tb_top
    import fsp_pkg::*;
;
    logic             core_clk = 1'b0;
    logic             rst_b = 1'b0;
    logic             nv_init_b = 1'b0;
    logic             cmd_valid;
    logic [2:0]       cmd_op;
    logic [SEC_W-1:0] cmd_sector;
    logic             cmd_data;
    logic             wp_b;
    logic             ready, busy, rej, pgo, ego, vval, vdyb, vppb, vlock, lock, worn;
    logic [SEC_W-1:0] asec;
    int               miscompares = 0;
    int               checks_done = 0;

    always #50 core_clk = ~core_clk;

    fsp_host_model host (.clk(core_clk), .cmd_ready(ready), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_sector(cmd_sector), .cmd_data(cmd_data), .wp_b(wp_b));

    fsp_sector_protect uut (.CORE_CLK(core_clk), .RST_B(rst_b), .NV_INIT_B(nv_init_b),
        .WP_B(wp_b), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op), .CMD_SECTOR(cmd_sector),
        .CMD_DATA(cmd_data), .CMD_READY(ready), .POLL_BUSY(busy), .CMD_REJECT(rej),
        .ARRAY_PROG_GO(pgo), .ARRAY_ERASE_GO(ego), .ARRAY_SECTOR(asec),
        .VERIFY_VALID(vval), .VERIFY_DYB(vdyb), .VERIFY_PPB(vppb), .VERIFY_LOCK(vlock),
        .LOCK_STATE(lock), .PPB_WORN(worn));

    // ******************************
    // shared tasks
    // ******************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // command, then reject, go pulses, sector and length of polling
    task automatic run(input logic [2:0] op, input logic [5:0] sec, input logic d,
                       input logic er, input logic [1:0] eg, input int eb);
        int n;
        host.send(op, sec, d);
        check(rej, er);
        check({pgo, ego}, eg);
        if (eg != 2'h0) check(asec, sec);
        n = 0;
        while (busy === 1'b1 && n < 600) begin
            n++;
            @(posedge core_clk);
            #1;
        end
        check(n, eb);
        check(ready, 1'b1);
    endtask

    task automatic verify(input logic [5:0] sec, input logic [2:0] exp);
        host.send(OP_VERIFY, sec, 1'b0);
        check(vval, 1'b1);
        check({vdyb, vppb, vlock}, exp);
    endtask

    initial begin
        #1000000;
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        nv_init_b = 1'b1;
        // ******************************
        // state after reset
        // ******************************
        check({ready, busy, lock, worn}, 4'h8);
        verify(6'd20, 3'h0);
        $display("reset state test done");
        // ******************************
        // dynamic bits and rejected operations
        // ******************************
        run(OP_DYB_WRITE, 6'd20, 1'b1, 1'b0, 2'h0, 0);
        verify(6'd20, 3'h4);
        run(OP_PROG, 6'd20, 1'b0, 1'b1, 2'h0, PROG_POLL_CYC);
        run(OP_ERASE, 6'd20, 1'b0, 1'b1, 2'h0, ERASE_POLL_CYC);
        run(OP_DYB_WRITE, 6'd20, 1'b0, 1'b0, 2'h0, 0);
        run(OP_PROG, 6'd20, 1'b0, 1'b0, 2'h2, 0);
        run(3'h7, 6'd20, 1'b0, 1'b1, 2'h0, 0);
        $display("dynamic test done");
        // ******************************
        // persistent bits and grouping
        // ******************************
        run(OP_PPB_PROG, 6'd9, 1'b0, 1'b0, 2'h0, PPB_OP_CYC + 1);
        verify(6'd10, 3'h2);
        verify(6'd11, 3'h0);
        run(OP_PROG, 6'd8, 1'b0, 1'b1, 2'h0, PROG_POLL_CYC);
        run(OP_PPB_PROG, 6'd7, 1'b0, 1'b0, 2'h0, PPB_OP_CYC + 1);
        verify(6'd6, 3'h0);
        verify(6'd7, 3'h2);
        host.erase_all();
        verify(6'd10, 3'h0);
        verify(6'd7, 3'h0);
        check(worn, 1'b0);
        $display("persistent test done");
        // ******************************
        // lock and write-protect pin
        // ******************************
        run(OP_PPB_PROG, 6'd30, 1'b0, 1'b0, 2'h0, PPB_OP_CYC + 1);
        host.secure_boot();
        check(lock, 1'b1);
        verify(6'd5, 3'h1);
        run(OP_PROG, 6'd0, 1'b0, 1'b1, 2'h0, PROG_POLL_CYC);
        run(OP_PROG, 6'd1, 1'b0, 1'b1, 2'h0, PROG_POLL_CYC);
        run(OP_ERASE, 6'd2, 1'b0, 1'b0, 2'h1, 0);
        host.release_wp();
        run(OP_PROG, 6'd0, 1'b0, 1'b0, 2'h2, 0);
        run(OP_PPB_PROG, 6'd40, 1'b0, 1'b1, 2'h0, 0);
        run(OP_PPB_ERASE, 6'd0, 1'b0, 1'b1, 2'h0, 0);
        verify(6'd30, 3'h3);
        verify(6'd40, 3'h1);
        run(OP_DYB_WRITE, 6'd40, 1'b1, 1'b0, 2'h0, 0);
        verify(6'd40, 3'h5);
        run(OP_LOCK_SET, 6'd0, 1'b0, 1'b0, 2'h0, 0);
        check(lock, 1'b1);
        $display("lock test done");
        // ******************************
        // hardware reset in mid-run
        // ******************************
        rst_b = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        check(lock, 1'b0);
        verify(6'd40, 3'h0);
        verify(6'd30, 3'h2);
        run(OP_PPB_PROG, 6'd40, 1'b0, 1'b0, 2'h0, PPB_OP_CYC + 1);
        $display("second reset test done");
        wrap_up();
    end
endmodule // tb_top
